// File: verilog/phy_irq_pkg.sv
package phy_irq_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int BYTE_W = 8;
    localparam int REG_W = 16;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = ADDR_W - IDX_LSB;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h1D;
    localparam logic [IDX_W-1:0] IDX_ENABLE = 6'h1E;
    localparam logic [IDX_W-1:0] IDX_SPECIAL = 6'h1F;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h20;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h21;

    // event flag and enable layout, bits 7..1
    localparam int EVT_LO = 1;
    localparam int EVT_HI = 7;
    localparam int EVT_W = EVT_HI - EVT_LO + 1;
    localparam logic [REG_W-1:0] ENABLE_RW_MASK = 16'h00FE;
    localparam logic [REG_W-1:0] ENABLE_RESET = 16'h0000;

    // special link status layout
    localparam int AN_DONE_BIT = 12;
    localparam int PATTERN_HI = 11;
    localparam int PATTERN_LO = 5;
    localparam int SPEED_HI = 4;
    localparam int SPEED_LO = 2;
    localparam logic [PATTERN_HI-PATTERN_LO:0] PATTERN_VALUE = 7'h02;
    localparam logic [REG_W-1:0] SPECIAL_RW_MASK = 16'h0FE3;
    localparam logic [REG_W-1:0] SPECIAL_RW_RESET = 16'h0040;

    // speed and duplex codes
    localparam logic [2:0] SPD_NONE = 3'h0;
    localparam logic [2:0] SPD_10_HALF = 3'h1;
    localparam logic [2:0] SPD_100_HALF = 3'h2;
    localparam logic [2:0] SPD_10_FULL = 3'h5;
    localparam logic [2:0] SPD_100_FULL = 3'h6;
    localparam logic [2:0] SPD_RESET_EXT_MII = SPD_100_HALF;
    localparam logic [2:0] SPD_RESET_INTERNAL = SPD_NONE;

    // system interrupt status bits
    localparam int SIRQ_W = 3;
    localparam int SIRQ_PHY = 0;
    localparam int SIRQ_AN = 1;
    localparam int SIRQ_PATTERN = 2;
    localparam logic [SIRQ_W-1:0] SIRQ_RESET = 3'h0;

    // one-cycle event detects, msb maps to flag bit 7
    typedef struct packed {
        logic energyDetected;
        logic autonegDone;
        logic remoteFault;
        logic linkDown;
        logic partnerAck;
        logic parallelDetectFault;
        logic pageReceived;
    } phy_events_s;

    // resolved link report from the phy core
    typedef struct packed {
        logic valid;
        logic [2:0] code;
        logic autonegComplete;
    } link_report_s;

endpackage

// File: verilog/event_latch.sv
`timescale 1ns/100ps
module event_latch
    import phy_irq_pkg::*;
(
    input logic mclk,
    input logic reset_n,
    input logic ce,
    input logic detect,
    input logic enable,
    input logic clear,
    output logic flag
);

    logic flag_reg;
    logic flag_next;

    // only an enabled event latches; a set in the clear cycle survives
    assign flag_next = (detect & enable) | (flag_reg & ~clear);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            flag_reg <= 1'b0;
        else if (ce)
            flag_reg <= flag_next;
    end

    assign flag = flag_reg;

endmodule // event_latch

// File: verilog/link_status_capture.sv
`timescale 1ns/100ps
module link_status_capture
    import phy_irq_pkg::*;
(
    input logic mclk,
    input logic reset_n,
    input logic ce,
    input logic extMiiMode,
    input link_report_s report,
    output logic [2:0] speedCode,
    output logic autonegDone
);

    logic armed_reg;
    logic [2:0] speed_reg;
    logic autonegDone_reg;

    // strap is a port, so it is caught on the first edge after release
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            armed_reg <= 1'b0;
            speed_reg <= SPD_RESET_INTERNAL;
        end
        else if (ce)
        begin
            if (!armed_reg)
            begin
                armed_reg <= 1'b1;
                speed_reg <= extMiiMode ? SPD_RESET_EXT_MII : SPD_RESET_INTERNAL;
            end
            else if (report.valid)
                speed_reg <= report.code;
        end
    end

    // completion is a plain level, zero from reset
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            autonegDone_reg <= 1'b0;
        else if (ce)
            autonegDone_reg <= report.autonegComplete;
    end

    assign speedCode = speed_reg;
    assign autonegDone = autonegDone_reg;

endmodule // link_status_capture

// File: verilog/phy_interrupt_mask_and_status.sv
// Local design decision: register access over APB.
`timescale 1ns/100ps
module phy_interrupt_mask_and_status
    import phy_irq_pkg::*;
(
    input logic mclk,
    input logic reset_n,
    input logic ce,
    input logic [ADDR_W-1:0] paddr,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [DATA_W-1:0] pwdata,
    input logic [STRB_W-1:0] pstrb,
    output logic pready,
    output logic [DATA_W-1:0] prdata,
    output logic pslverr,
    input phy_events_s phyEvents,
    input link_report_s linkReport,
    input logic extMiiMode,
    output logic phyIrq,
    output logic irq
);

    // address decode, shared by read mux and write paths
    function automatic logic hitIndex(
        input logic [ADDR_W-1:0] addr,
        input logic [IDX_W-1:0] idx
    );
        hitIndex = (addr[ADDR_W-1:IDX_LSB] == idx);
    endfunction

    // byte lanes that cover the 16-bit registers
    function automatic logic [REG_W-1:0] laneMask(input logic [STRB_W-1:0] strb);
        laneMask = {{BYTE_W{strb[1]}}, {BYTE_W{strb[0]}}};
    endfunction

    // registered state
    logic pready_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic pslverr_reg;
    logic [REG_W-1:0] enable_reg;
    logic [REG_W-1:0] specialRw_reg;
    logic [SIRQ_W-1:0] sysStatus_reg;
    logic [SIRQ_W-1:0] sysMask_reg;
    logic phyIrq_reg;
    logic irq_reg;
    logic anDonePrev_reg;

    // bus decode
    logic accessPhase;
    logic xferDone;
    logic wrDone;
    logic rdDone;
    logic [REG_W-1:0] wrMask;
    logic [DATA_W-1:0] readWord;
    logic mapped;

    // event and status datapath
    logic [EVT_W-1:0] eventVec;
    logic [EVT_W-1:0] enableBits;
    logic [EVT_W-1:0] flagBits;
    logic [EVT_W-1:0] flagClear;
    logic [REG_W-1:0] flagVec;
    logic [REG_W-1:0] specialVec;
    logic [2:0] speedCode;
    logic autonegDone;
    logic phyIrq_next;
    logic [SIRQ_W-1:0] sysSet;
    logic [SIRQ_W-1:0] sysClear;
    logic [SIRQ_W-1:0] sysStatus_next;
    logic badPattern;

    // apb handshake; one wait state keeps every answer in a flop
    assign accessPhase = psel & penable;
    assign xferDone = accessPhase & pready_reg;
    assign wrDone = xferDone & pwrite;
    assign rdDone = xferDone & ~pwrite;
    assign wrMask = laneMask(pstrb);

    // pready lasts one cycle; low ce stalls the wait state
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            pready_reg <= 1'b0;
        else if (ce)
            pready_reg <= accessPhase & ~pready_reg;
    end

    // read data and error are captured on the same edge that raises pready
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (accessPhase & ~pready_reg)
            begin
                prdata_reg <= pwrite ? '0 : readWord;
                pslverr_reg <= ~mapped;
            end
            else if (xferDone)
            begin
                prdata_reg <= '0;
                pslverr_reg <= 1'b0;
            end
        end
    end

    // the mux has a full cycle, the word is latched on the edge that raises pready
    // register read mux; unmapped words read zero with an error
    always_comb
    begin
        readWord = '0;
        mapped = 1'b1;
        if (hitIndex(paddr, IDX_FLAGS))
            readWord[REG_W-1:0] = flagVec;
        else if (hitIndex(paddr, IDX_ENABLE))
            readWord[REG_W-1:0] = enable_reg;
        else if (hitIndex(paddr, IDX_SPECIAL))
            readWord[REG_W-1:0] = specialVec;
        else if (hitIndex(paddr, IDX_IRQ_STATUS))
            readWord[SIRQ_W-1:0] = sysStatus_reg;
        else if (hitIndex(paddr, IDX_IRQ_MASK))
            readWord[SIRQ_W-1:0] = sysMask_reg;
        else
            mapped = 1'b0;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            enable_reg <= ENABLE_RESET;
        else if (ce && wrDone && hitIndex(paddr, IDX_ENABLE))
            enable_reg <= (enable_reg & ~(wrMask & ENABLE_RW_MASK))
                | (pwdata[REG_W-1:0] & wrMask & ENABLE_RW_MASK);
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            specialRw_reg <= SPECIAL_RW_RESET;
        else if (ce && wrDone && hitIndex(paddr, IDX_SPECIAL))
            specialRw_reg <= (specialRw_reg & ~(wrMask & SPECIAL_RW_MASK))
                | (pwdata[REG_W-1:0] & wrMask & SPECIAL_RW_MASK);
    end

    // a write that breaks the fixed pattern is flagged to software
    // the bits are stored as written; only the status bit reports it
    assign badPattern = wrDone & hitIndex(paddr, IDX_SPECIAL)
        & (pwdata[PATTERN_HI:PATTERN_LO] != PATTERN_VALUE);

    // event bits line up with flag register bits 7..1
    assign eventVec = phyEvents;
    assign enableBits = enable_reg[EVT_HI:EVT_LO];

    // clear on read
    // only bits that reached prdata are cleared, so no event goes unseen
    assign flagClear = {EVT_W{rdDone & hitIndex(paddr, IDX_FLAGS)}}
        & prdata_reg[EVT_HI:EVT_LO];

    // gated latching flags
    // one latch per source; latch gi drives flag bit gi+1
    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi = gi + 1)
        begin : gen_flag
            event_latch u_latch (
                .mclk(mclk),
                .reset_n(reset_n),
                .ce(ce),
                .detect(eventVec[gi]),
                .enable(enableBits[gi]),
                .clear(flagClear[gi]),
                .flag(flagBits[gi])
            );
        end
    endgenerate

    always_comb
    begin
        flagVec = '0;
        flagVec[EVT_HI:EVT_LO] = flagBits;
    end

    link_status_capture u_link (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .extMiiMode(extMiiMode),
        .report(linkReport),
        .speedCode(speedCode),
        .autonegDone(autonegDone)
    );

    always_comb
    begin
        specialVec = specialRw_reg;
        specialVec[AN_DONE_BIT] = autonegDone;
        specialVec[SPEED_HI:SPEED_LO] = speedCode;
    end

    assign phyIrq_next = |(flagVec & enable_reg);

    // registered so the pin never glitches on a mask write
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            phyIrq_reg <= 1'b0;
        else if (ce)
            phyIrq_reg <= phyIrq_next;
    end

    // completion edge for the system status
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            anDonePrev_reg <= 1'b0;
        else if (ce)
            anDonePrev_reg <= autonegDone;
    end

    // system events: phy interrupt rise, completion rise, bad pattern
    always_comb
    begin
        sysSet = '0;
        sysSet[SIRQ_PHY] = phyIrq_next & ~phyIrq_reg;
        sysSet[SIRQ_AN] = autonegDone & ~anDonePrev_reg;
        sysSet[SIRQ_PATTERN] = badPattern;
    end

    // write one to clear; a set in the same cycle wins
    assign sysClear = (wrDone && hitIndex(paddr, IDX_IRQ_STATUS) && pstrb[0])
        ? pwdata[SIRQ_W-1:0] : '0;
    assign sysStatus_next = sysSet | (sysStatus_reg & ~sysClear);

    // sticky bits hold while ce is low
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            sysStatus_reg <= SIRQ_RESET;
        else if (ce)
            sysStatus_reg <= sysStatus_next;
    end

    // system mask, low byte lane only
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            sysMask_reg <= SIRQ_RESET;
        else if (ce && wrDone && hitIndex(paddr, IDX_IRQ_MASK) && pstrb[0])
            sysMask_reg <= pwdata[SIRQ_W-1:0];
    end

    // level output; one cycle behind the status bits
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            irq_reg <= 1'b0;
        else if (ce)
            irq_reg <= |(sysStatus_reg & sysMask_reg);
    end

    // every output is driven by a flop
    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign phyIrq = phyIrq_reg;
    assign irq = irq_reg;

endmodule // phy_interrupt_mask_and_status

// File: bench/phy_irq_checker_assertions.sv
`timescale 1ns/100ps
module phy_irq_checker
    import phy_irq_pkg::*;
(
    input logic mclk,
    input logic reset_n,
    input logic [ADDR_W-1:0] paddr,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic pready,
    input logic [DATA_W-1:0] prdata,
    input logic pslverr,
    input phy_events_s phyEvents,
    input logic phyIrq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // decoded map is one contiguous run of indices
    logic mapped;
    assign mapped = (paddr[7:2] >= IDX_FLAGS) && (paddr[7:2] <= IDX_IRQ_MASK);

    // setup, then exactly one wait state
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_oneWait;
        !pready ##1 pready;
    endsequence
    property p_oneWait;
        s_setup |=> s_oneWait;
    endproperty
    a_oneWait: assert property (p_oneWait) else $error("pready late or early");

    property p_readyPulse;
        pready |=> !pready;
    endproperty
    a_readyPulse: assert property (p_readyPulse) else $error("pready held");

    property p_idle;
        !pready |-> prdata == '0 && !pslverr;
    endproperty
    a_idle: assert property (p_idle) else $error("bus outputs not idle");

    property p_unmapped;
        pready && !mapped |-> pslverr && prdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");

    property p_mapped;
        pready && mapped |-> !pslverr && prdata[31:16] == 16'h0000;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");

    property p_enableRsvd;
        pready && paddr[7:2] == IDX_ENABLE |-> prdata[15:8] == 8'h00 && !prdata[0];
    endproperty
    a_enableRsvd: assert property (p_enableRsvd) else $error("enable reserved set");

    property p_flagsRsvd;
        pready && paddr[7:2] == IDX_FLAGS |-> prdata[15:8] == 8'h00 && !prdata[0];
    endproperty
    a_flagsRsvd: assert property (p_flagsRsvd) else $error("flags reserved set");

    property p_irqCause;
        $rose(phyIrq) |-> $past(|phyEvents, 1) || $past(|phyEvents, 2) || $past(pready, 2);
    endproperty
    a_irqCause: assert property (p_irqCause) else $error("phyIrq rose unprompted");

    property p_irqClear;
        $fell(phyIrq) |-> $past(pready, 2);
    endproperty
    a_irqClear: assert property (p_irqClear) else $error("phyIrq fell unprompted");
endmodule // phy_irq_checker

bind phy_interrupt_mask_and_status phy_irq_checker chk (.mclk(mclk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .phyEvents(phyEvents), .phyIrq(phyIrq));

// File: bench/phy_interrupt_mask_and_status_tb.sv
`timescale 1ns/100ps
module phy_interrupt_mask_and_status_tb
    import phy_irq_pkg::*;
;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = '0;
    logic pready, pslverr, phyIrq, irq;
    logic [DATA_W-1:0] prdata;
    phy_events_s phyEvents = '0;
    link_report_s linkReport = '0;
    logic extMiiMode = 1'b0;
    logic ce = 1'b1;
    logic [STRB_W-1:0] pstrb = 4'hF;
    int n_errors = 0;
    int checks_done = 0;

    phy_interrupt_mask_and_status DUT (.mclk(mclk), .reset_n(reset_n), .ce(ce),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .phyEvents(phyEvents), .linkReport(linkReport), .extMiiMode(extMiiMode),
        .phyIrq(phyIrq), .irq(irq));

    // 50 MHz
    initial
    begin
        forever #10 mclk = ~mclk;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic xfer(input logic [IDX_W-1:0] idx, input logic wr, input logic [15:0] wd,
        output logic [31:0] rdat, output logic er);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        paddr <= {idx, 2'b00};
        pwrite <= wr;
        pwdata <= {16'h0000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_errors++;
            conclude();
        end
    endtask

    task automatic regWrite(input logic [IDX_W-1:0] idx, input logic [15:0] wd);
        logic [31:0] d;
        logic e;
        xfer(idx, 1'b1, wd, d, e);
    endtask

    task automatic regRead(input logic [IDX_W-1:0] idx, input logic [15:0] exp, input string what);
        logic [31:0] d;
        logic e;
        xfer(idx, 1'b0, 16'h0000, d, e);
        check(what, {16'h0000, exp}, d);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // one-cycle event detects, msb is energy detected
    task automatic pulse(input logic [6:0] v);
        @(posedge mclk);
        phyEvents <= phy_events_s'(v);
        @(posedge mclk);
        phyEvents <= '0;
    endtask

    task automatic doReset(input logic ext);
        @(posedge mclk);
        reset_n <= 1'b0;
        extMiiMode <= ext;
        tick(5);
        reset_n <= 1'b1;
    endtask

    initial
    begin
        logic [31:0] d;
        logic e;
        logic [2:0] codes[4];
        codes = '{SPD_10_HALF, SPD_100_HALF, SPD_10_FULL, SPD_100_FULL};
        doReset(1'b0);
        // reset values and writable bits
        regRead(IDX_ENABLE, 16'h0000, "enable");
        regRead(IDX_SPECIAL, 16'h0040, "special");
        regWrite(IDX_ENABLE, 16'hFFFF);
        regRead(IDX_ENABLE, 16'h00FE, "enable");
        regWrite(IDX_ENABLE, 16'h0000);
        pulse(7'h7F);
        tick(2);
        check("phyIrq", 32'h0, {31'h0, phyIrq});
        regRead(IDX_FLAGS, 16'h0000, "flags");
        $display("test reset and masking done");
        // one enable at a time, every source fired
        for (int b = 1; b <= 7; b++)
        begin
            regWrite(IDX_ENABLE, 16'h0001 << b);
            pulse(7'h7F);
            tick(2);
            check("phyIrq", 32'h1, {31'h0, phyIrq});
            regRead(IDX_FLAGS, 16'h0001 << b, "flags");
            regRead(IDX_FLAGS, 16'h0000, "flags");
            check("phyIrq", 32'h0, {31'h0, phyIrq});
        end
        $display("test event gating done");
        // low ce freezes the latches; an event then is lost
        regWrite(IDX_ENABLE, 16'h00FE);
        ce <= 1'b0;
        pulse(7'h7F);
        ce <= 1'b1;
        regRead(IDX_FLAGS, 16'h0000, "flagsFrozen");
        // lane 0 off leaves the enable bits untouched
        pstrb <= 4'hE;
        regWrite(IDX_ENABLE, 16'h0000);
        pstrb <= 4'hF;
        regRead(IDX_ENABLE, 16'h00FE, "enableLanes");
        // existing flags stay when their enable drops
        pulse(7'h7F);
        regWrite(IDX_ENABLE, 16'h0000);
        tick(2);
        check("phyIrq", 32'h0, {31'h0, phyIrq});
        regRead(IDX_FLAGS, 16'h00FE, "flagsKept");
        $display("test enable, lanes and ce done");
        // resolved link codes with autoneg complete
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            linkReport <= '{1'b1, codes[i], 1'b1};
            @(posedge mclk);
            linkReport.valid <= 1'b0;
            regRead(IDX_SPECIAL, {4'h1, PATTERN_VALUE, codes[i], 2'h0}, "special");
        end
        // read-only bits ignore writes
        regWrite(IDX_SPECIAL, 16'hF05F);
        regRead(IDX_SPECIAL, 16'h105B, "special");
        $display("test link status done");
        // system interrupt raise, mask, clear
        regWrite(IDX_IRQ_MASK, 16'h0007);
        regWrite(IDX_SPECIAL, 16'h0000);
        tick(2);
        regRead(IDX_IRQ_STATUS, 16'h0007, "irqStatus");
        check("irq", 32'h1, {31'h0, irq});
        regWrite(IDX_IRQ_MASK, 16'h0000);
        tick(2);
        check("irq", 32'h0, {31'h0, irq});
        regWrite(IDX_IRQ_STATUS, 16'h0007);
        regRead(IDX_IRQ_STATUS, 16'h0000, "irqStatus");
        regWrite(IDX_SPECIAL, 16'h0040);
        xfer(6'h00, 1'b0, 16'h0000, d, e);
        check("unmappedErr", 32'h1, {31'h0, e});
        check("unmappedData", 32'h0, d);
        $display("test interrupt and unmapped done");
        // external mii strap, second reset
        linkReport <= '0;
        doReset(1'b1);
        regRead(IDX_SPECIAL, 16'h0048, "special");
        regRead(IDX_ENABLE, 16'h0000, "enable");
        $display("test second reset done");
        conclude();
    end
endmodule // phy_interrupt_mask_and_status_tb
